// ### src/dco_chain_node.sv
// daisy chain output port of one node: forwards or sources the chain
`timescale 1ns/1ps

// Contract
// - selected node drives response, frame valid and data byte, obeys commands
// - deselected: forward inputs, three stage delay
// - deselected: ignore commands, no own response
// - upstream supplies reference clock, node paces serial lines by its edges
// - sample inputs on clock rise only; the frame source tx_valid, tx_byte and tx_last are taken on the fall
// - command line always copied downstream
// - honour status query and send request
// - selected ignores upstream response, else forwards
// - selected drives response from own logic
// - upstream holds frame valid low during frame
// - frame valid own when selected, else forwarded
// - data byte own when selected, else forwarded
// - bytes count only while frame valid low
// - reference clock always forwarded downstream
// - status query answers with fullness count
// - command selects bank to search
module dco_chain_node #(
    parameter int FILL_W = dco_pkg::FILL_W,
    parameter int BYTE_W = dco_pkg::BYTE_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // chain link
    dco_chain_if.dev_mp            link,
    // frame source and fullness from the accumulator side
    input  wire logic [FILL_W-1:0] fill_count,
    input  wire logic [BYTE_W-1:0] tx_byte,
    input  wire logic              tx_valid,
    input  wire logic              tx_last,
    output logic                   tx_take,
    // status
    output logic                   bank_sel,
    output logic                   selected
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam int CNT_W = dco_pkg::CNT_W;
    localparam logic [CNT_W-1:0] CMD_LAST  = CNT_W'(dco_pkg::CMD_BITS - 1);
    localparam logic [CNT_W-1:0] RESP_LAST = CNT_W'(FILL_W + 1);

    typedef enum logic [1:0] {
        DCO_IDLE,
        DCO_CMD,
        DCO_RESP,
        DCO_SEND
    } dco_node_state_t;

    typedef struct packed {
        // two stage synchronisers, [0] is the first flop
        logic [1:0]             ref_sy;
        logic                   ref_d;
        logic [1:0]             sel_sy;
        logic [1:0]             cmd_sy;
        logic [1:0]             resp_sy;
        logic [1:0]             frm_sy;
        logic [1:0][BYTE_W-1:0] byte_sy;
        // own protocol engine
        dco_node_state_t        state;
        logic [CNT_W-1:0]       cnt;
        logic [FILL_W:0]        sh;
        logic                   last;
        logic                   own_resp;
        logic                   own_frm_n;
        logic [BYTE_W-1:0]      own_byte;
        // output stage
        logic                   ref_out;
        logic                   cmd_out;
        logic                   resp_out;
        logic                   frm_out_n;
        logic [BYTE_W-1:0]      byte_out;
        logic                   tx_take;
        logic                   bank_sel;
        logic                   selected;
    } dco_node_reg_t;

    dco_node_reg_t r;
    dco_node_reg_t n;

    logic rise;
    logic fall;
    logic sel;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        n = r;
        // input stages one and two
        n.ref_sy[0]  = link.chain_ref_clk_in;
        n.ref_sy[1]  = r.ref_sy[0];
        n.sel_sy[0]  = link.chain_select_n;
        n.sel_sy[1]  = r.sel_sy[0];
        n.cmd_sy[0]  = link.serial_cmd_in;
        n.cmd_sy[1]  = r.cmd_sy[0];
        n.resp_sy[0] = link.serial_resp_in;
        n.resp_sy[1] = r.resp_sy[0];
        n.frm_sy[0]  = link.frame_valid_in_n;
        n.frm_sy[1]  = r.frm_sy[0];
        n.byte_sy[0] = link.chain_byte_in;
        n.byte_sy[1] = r.byte_sy[0];
        n.ref_d      = r.ref_sy[1];

        // edges of the reference clock pace the serial lines
        rise = r.ref_sy[1] & ~r.ref_d;
        fall = ~r.ref_sy[1] & r.ref_d;
        sel  = ~r.sel_sy[1];

        n.tx_take = 1'h0;

        if (!sel)
        begin
            // a node that loses its select mid frame drops what it was doing
            n.state     = DCO_IDLE;
            n.own_resp  = dco_pkg::LINE_IDLE;
            n.own_frm_n = 1'h1;
        end
        else
        begin
            unique case (r.state)
                DCO_IDLE:
                begin
                    if (rise && r.cmd_sy[1] == dco_pkg::START_BIT)
                    begin
                        n.state = DCO_CMD;
                        n.cnt   = '0;
                    end
                end
                DCO_CMD:
                begin
                    if (rise)
                    begin
                        n.sh  = {r.sh[FILL_W-1:0], r.cmd_sy[1]};
                        n.cnt = r.cnt + 1'h1;
                        if (r.cnt == CMD_LAST)
                        begin
                            unique case (r.sh[1:0])
                                dco_pkg::OP_STATUS:
                                begin
                                    n.sh    = {dco_pkg::START_BIT, fill_count};
                                    n.cnt   = '0;
                                    n.state = DCO_RESP;
                                end
                                dco_pkg::OP_SEND:
                                begin
                                    n.last  = 1'h0;
                                    n.state = DCO_SEND;
                                end
                                dco_pkg::OP_BANK:
                                begin
                                    n.bank_sel = r.cmd_sy[1];
                                    n.state    = DCO_IDLE;
                                end
                                default:
                                begin
                                    n.state = DCO_IDLE;
                                end
                            endcase
                        end
                    end
                end
                DCO_RESP:
                begin
                    // ones shift in behind the count, so the line idles high after it
                    if (fall)
                    begin
                        n.own_resp = r.sh[FILL_W];
                        n.sh       = {r.sh[FILL_W-1:0], dco_pkg::LINE_IDLE};
                        n.cnt      = r.cnt + 1'h1;
                        if (r.cnt == RESP_LAST)
                        begin
                            n.state = DCO_IDLE;
                        end
                    end
                end
                DCO_SEND:
                begin
                    if (fall)
                    begin
                        if (!r.last && tx_valid)
                        begin
                            n.own_byte  = tx_byte;
                            n.own_frm_n = 1'h0;
                            n.last      = tx_last;
                            n.tx_take   = 1'h1;
                        end
                        else
                        begin
                            // a gap in the source ends the frame; waiting only before the first byte
                            n.own_frm_n = 1'h1;
                            if (!r.own_frm_n)
                            begin
                                n.state = DCO_IDLE;
                            end
                        end
                    end
                end
            endcase
        end

        // output stage, the third register of every forwarded path
        n.ref_out   = r.ref_sy[1];
        n.cmd_out   = r.cmd_sy[1];
        n.resp_out  = sel ? r.own_resp  : r.resp_sy[1];
        n.frm_out_n = sel ? r.own_frm_n : r.frm_sy[1];
        n.byte_out  = sel ? r.own_byte  : r.byte_sy[1];
        n.selected  = sel;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r           <= '0;
            r.sel_sy    <= 2'h3;
            r.cmd_sy    <= 2'h3;
            r.resp_sy   <= 2'h3;
            r.frm_sy    <= 2'h3;
            r.own_resp  <= 1'h1;
            r.own_frm_n <= 1'h1;
            r.cmd_out   <= 1'h1;
            r.resp_out  <= 1'h1;
            r.frm_out_n <= 1'h1;
        end
        else
        begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // the reference clock out is resampled by clk, so it carries up to one clk of jitter
    assign link.chain_ref_clk_out = r.ref_out;
    assign link.serial_cmd_out    = r.cmd_out;
    assign link.serial_resp_out   = r.resp_out;
    assign link.frame_valid_out_n = r.frm_out_n;
    assign link.chain_byte_out    = r.byte_out;
    assign tx_take                = r.tx_take;
    assign bank_sel               = r.bank_sel;
    assign selected               = r.selected;

endmodule : dco_chain_node

// ### include/dco_pkg.sv
// shared constants for the daisy chain output port and its upstream end
package dco_pkg;

    // ------------------------------------------------------------------
    // link widths and timing
    // ------------------------------------------------------------------
    localparam int BYTE_W       = 8;
    localparam int FILL_W       = 14;   // fullness count, up to 16000 bins
    localparam int CNT_W        = 5;
    localparam int REF_HALF_CYC = 8;    // reference clock half period in clk cycles
    localparam int PIPE_STAGES  = 3;    // pin to pin depth of every forwarded path

    // ------------------------------------------------------------------
    // serial command format: start bit, opcode, one argument bit
    // ------------------------------------------------------------------
    localparam int         OP_W      = 2;
    localparam int         CMD_BITS  = OP_W + 1;
    localparam logic [1:0] OP_STATUS = 2'h1;
    localparam logic [1:0] OP_SEND   = 2'h2;
    localparam logic [1:0] OP_BANK   = 2'h3;
    localparam logic       LINE_IDLE = 1'h1;
    localparam logic       START_BIT = 1'h0;

endpackage : dco_pkg

// ### include/dco_chain_if.sv
// one hop of the daisy chain between the upstream end and one node
`timescale 1ns/1ps
interface dco_chain_if;
    logic                     chain_ref_clk_in;
    logic                     chain_select_n;
    logic                     serial_cmd_in;
    logic                     serial_resp_in;
    logic                     frame_valid_in_n;
    logic [dco_pkg::BYTE_W-1:0] chain_byte_in;
    logic                     chain_ref_clk_out;
    logic                     serial_cmd_out;
    logic                     serial_resp_out;
    logic                     frame_valid_out_n;
    logic [dco_pkg::BYTE_W-1:0] chain_byte_out;

    // node end; the upstream node inputs are driven by whoever sits before it
    modport dev_mp (
        input  chain_ref_clk_in, chain_select_n, serial_cmd_in,
        input  serial_resp_in, frame_valid_in_n, chain_byte_in,
        output chain_ref_clk_out, serial_cmd_out, serial_resp_out,
        output frame_valid_out_n, chain_byte_out
    );

    // upstream end
    modport host_mp (
        output chain_ref_clk_in, chain_select_n, serial_cmd_in,
        input  serial_resp_out, frame_valid_out_n, chain_byte_out
    );
endinterface : dco_chain_if

// ### src/dco_chain_host.sv
// upstream end of the chain: makes the reference clock, sends commands, receives frames
`timescale 1ns/1ps
module dco_chain_host #(
    parameter int REF_HALF = dco_pkg::REF_HALF_CYC,
    parameter int FILL_W   = dco_pkg::FILL_W,
    parameter int BYTE_W   = dco_pkg::BYTE_W
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // chain link
    dco_chain_if.host_mp                link,
    // command request
    input  wire logic                   node_select_n,
    input  wire logic                   cmd_go,
    input  wire logic [dco_pkg::OP_W-1:0] cmd_op,
    input  wire logic                   cmd_arg,
    output logic                        busy,
    // answers
    output logic [FILL_W-1:0]           fill_count,
    output logic                        fill_valid,
    output logic [BYTE_W-1:0]           rx_byte,
    output logic                        rx_valid,
    output logic                        rx_end
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam int CNT_W = dco_pkg::CNT_W;
    localparam int CB    = dco_pkg::CMD_BITS;
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(REF_HALF - 1);
    localparam logic [CNT_W-1:0] CMD_DONE  = CNT_W'(CB + 1);
    localparam logic [CNT_W-1:0] FILL_LAST = CNT_W'(FILL_W - 1);

    typedef enum logic [1:0] {
        DCO_H_IDLE,
        DCO_H_CMD,
        DCO_H_RESP,
        DCO_H_RECV
    } dco_host_state_t;

    typedef struct packed {
        logic [CNT_W-1:0]       div;
        logic                   ref_clk;
        logic                   sel_n;
        logic                   cmd;
        logic [CB:0]            sh;
        logic [dco_pkg::OP_W-1:0] op;
        logic [CNT_W-1:0]       cnt;
        dco_host_state_t        state;
        logic [1:0]             resp_sy;
        logic [1:0]             frm_sy;
        logic [1:0][BYTE_W-1:0] byte_sy;
        logic                   got_start;
        logic                   seen;
        logic [FILL_W-1:0]      rsh;
        logic                   busy;
        logic [FILL_W-1:0]      fill_count;
        logic                   fill_valid;
        logic [BYTE_W-1:0]      rx_byte;
        logic                   rx_valid;
        logic                   rx_end;
    } dco_host_reg_t;

    dco_host_reg_t r;
    dco_host_reg_t n;

    logic fall;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        n = r;
        n.resp_sy    = {r.resp_sy[0], link.serial_resp_out};
        n.frm_sy     = {r.frm_sy[0], link.frame_valid_out_n};
        n.byte_sy[0] = link.chain_byte_out;
        n.byte_sy[1] = r.byte_sy[0];
        n.sel_n      = node_select_n;
        n.fill_valid = 1'h0;
        n.rx_valid   = 1'h0;
        n.rx_end     = 1'h0;

        // divider makes the reference clock
        fall  = (r.div == HALF_LAST) && r.ref_clk;
        n.div = r.div + 1'h1;
        if (r.div == HALF_LAST)
        begin
            n.div     = '0;
            n.ref_clk = ~r.ref_clk;
        end

        // the link changes and is sampled on the falling edge, a half period from the node's sampling
        unique case (r.state)
            DCO_H_IDLE:
            begin
                if (cmd_go)
                begin
                    n.sh    = {dco_pkg::START_BIT, cmd_op, cmd_arg};
                    n.op    = cmd_op;
                    n.cnt   = '0;
                    n.busy  = 1'h1;
                    n.state = DCO_H_CMD;
                end
            end
            DCO_H_CMD:
            begin
                if (fall)
                begin
                    n.cmd = r.sh[CB];
                    n.sh  = {r.sh[CB-1:0], dco_pkg::LINE_IDLE};
                    n.cnt = r.cnt + 1'h1;
                    if (r.cnt == CMD_DONE)
                    begin
                        n.cnt = '0;
                        if (r.op == dco_pkg::OP_STATUS)
                        begin
                            n.state = DCO_H_RESP;
                        end
                        else if (r.op == dco_pkg::OP_SEND)
                        begin
                            n.state = DCO_H_RECV;
                        end
                        else
                        begin
                            n.busy  = 1'h0;
                            n.state = DCO_H_IDLE;
                        end
                    end
                end
            end
            DCO_H_RESP:
            begin
                if (fall)
                begin
                    if (!r.got_start)
                    begin
                        n.got_start = (r.resp_sy[1] == dco_pkg::START_BIT);
                    end
                    else
                    begin
                        n.rsh = {r.rsh[FILL_W-2:0], r.resp_sy[1]};
                        n.cnt = r.cnt + 1'h1;
                        if (r.cnt == FILL_LAST)
                        begin
                            n.fill_count = {r.rsh[FILL_W-2:0], r.resp_sy[1]};
                            n.fill_valid = 1'h1;
                            n.got_start  = 1'h0;
                            n.busy       = 1'h0;
                            n.state      = DCO_H_IDLE;
                        end
                    end
                end
            end
            DCO_H_RECV:
            begin
                if (fall)
                begin
                    if (!r.frm_sy[1])
                    begin
                        n.rx_byte  = r.byte_sy[1];
                        n.rx_valid = 1'h1;
                        n.seen     = 1'h1;
                    end
                    else if (r.seen)
                    begin
                        n.rx_end = 1'h1;
                        n.seen   = 1'h0;
                        n.busy   = 1'h0;
                        n.state  = DCO_H_IDLE;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r         <= '0;
            r.sel_n   <= 1'h1;
            r.cmd     <= 1'h1;
            r.sh      <= '1;
            r.resp_sy <= 2'h3;
            r.frm_sy  <= 2'h3;
        end
        else
        begin
            r <= n;
        end
    end

    assign link.chain_ref_clk_in = r.ref_clk;
    assign link.chain_select_n   = r.sel_n;
    assign link.serial_cmd_in    = r.cmd;
    assign busy                  = r.busy;
    assign fill_count            = r.fill_count;
    assign fill_valid            = r.fill_valid;
    assign rx_byte               = r.rx_byte;
    assign rx_valid              = r.rx_valid;
    assign rx_end                = r.rx_end;

endmodule : dco_chain_host

// ### testbench/dco_chain_assertions.sv
// concurrent checks on one hop of the daisy chain
`timescale 1ns/1ps
module dco_chain_assertions (
    // clock and reset
    input wire logic                       clk,
    input wire logic                       reset,
    // chain link
    input wire logic                       chain_ref_clk_in,
    input wire logic                       chain_select_n,
    input wire logic                       serial_cmd_in,
    input wire logic                       serial_resp_in,
    input wire logic                       frame_valid_in_n,
    input wire logic [dco_pkg::BYTE_W-1:0] chain_byte_in,
    input wire logic                       chain_ref_clk_out,
    input wire logic                       serial_cmd_out,
    input wire logic                       serial_resp_out,
    input wire logic                       frame_valid_out_n,
    input wire logic [dco_pkg::BYTE_W-1:0] chain_byte_out
);
    logic [2:0] up;
    logic [8:0] quiet;
    logic [3:0] ssh;
    logic       desel;
    logic       sel;

    // ------------------------------------------------------------
    // helpers: pipeline fill after reset, select history
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        ssh <= {ssh[2:0], chain_select_n};
        if (reset)
        begin
            up <= 3'h0;
            quiet <= 9'h1FF;
        end
        else
        begin
            up <= (up == 3'h7) ? up : up + 3'h1;
            // a reply runs on some sixteen reference periods past the last low command bit
            quiet <= !serial_cmd_in ? 9'h000 : (quiet == 9'h1FF) ? quiet : quiet + 9'h001;
        end
    end
    // select must be steady over the whole pipe, else the mux may still switch
    assign desel = (up == 3'h7) && (&ssh[3:1]);
    assign sel = (up == 3'h7) && !(|ssh[3:1]);

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_cmd_copy: assert property (up[2] |-> serial_cmd_out == $past(serial_cmd_in, 3))
        else $error("command line copy wrong");
    a_ref_copy: assert property (up[2] |-> chain_ref_clk_out == $past(chain_ref_clk_in, 3))
        else $error("reference clock copy wrong");
    a_resp_fwd: assert property (desel |-> serial_resp_out == $past(serial_resp_in, 3))
        else $error("response not forwarded");
    a_frame_fwd: assert property (desel |-> frame_valid_out_n == $past(frame_valid_in_n, 3))
        else $error("frame valid not forwarded");
    a_byte_fwd: assert property (desel |-> chain_byte_out == $past(chain_byte_in, 3))
        else $error("data byte not forwarded");
    a_path_align: assert property (desel && $changed(frame_valid_out_n) |->
        $past(frame_valid_in_n, 3) != $past(frame_valid_in_n, 4))
        else $error("frame valid path misaligned");
    a_resp_cause: assert property (sel && $fell(serial_resp_out) |-> quiet < 9'h12C)
        else $error("response without command");
    a_ref_edge: assert property ((&up) && $rose(chain_ref_clk_out) |->
        $past(chain_ref_clk_in, 3) && !$past(chain_ref_clk_in, 4))
        else $error("reference clock edge out of place");
endmodule : dco_chain_assertions

// ### testbench/tb_top.sv
// self-checking bench: host and node joined through one chain hop
`timescale 1ns/1ps
module tb_top;
    logic        clk, reset, node_select_n, cmd_go, cmd_arg, busy, fill_valid, rx_valid, rx_end;
    logic        tx_valid, tx_last, tx_take, bank_sel, selected, up_en, done, ended;
    logic [1:0]  cmd_op;
    logic [13:0] fill_in, fill_out, got_fill;
    logic [7:0]  tx_byte, rx_byte, frm [4];
    logic [7:0]  rxq [$];
    logic [8:0]  hist [$];
    int          n_errors, samples_checked, idx, k;
    integer      seed = 9;

    dco_chain_if ch();
    dco_chain_host i_dco_chain_host (.clk(clk), .reset(reset), .link(ch), .node_select_n(node_select_n),
        .cmd_go(cmd_go), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .busy(busy), .fill_count(fill_out),
        .fill_valid(fill_valid), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_end(rx_end));
    dco_chain_node i_dco_chain_node (.clk(clk), .reset(reset), .link(ch), .fill_count(fill_in),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last), .tx_take(tx_take),
        .bank_sel(bank_sel), .selected(selected));
    dco_chain_assertions i_dco_chain_assertions (.clk(clk), .reset(reset),
        .chain_ref_clk_in(ch.chain_ref_clk_in), .chain_select_n(ch.chain_select_n),
        .serial_cmd_in(ch.serial_cmd_in), .serial_resp_in(ch.serial_resp_in),
        .frame_valid_in_n(ch.frame_valid_in_n), .chain_byte_in(ch.chain_byte_in),
        .chain_ref_clk_out(ch.chain_ref_clk_out), .serial_cmd_out(ch.serial_cmd_out),
        .serial_resp_out(ch.serial_resp_out), .frame_valid_out_n(ch.frame_valid_out_n),
        .chain_byte_out(ch.chain_byte_out));

    // frame source: one byte per take, last flagged
    assign tx_valid = (idx < 4);
    assign tx_last = (idx == 3);
    assign tx_byte = frm[idx[1:0]];

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (tx_take === 1'h1)
            idx <= idx + 1;
        // upstream noise; a selected node must not let any of it through
        ch.serial_resp_in <= up_en ? 1'($random(seed)) : 1'h1;
        ch.frame_valid_in_n <= up_en ? 1'($random(seed)) : 1'h1;
        ch.chain_byte_in <= up_en ? 8'($random(seed)) : 8'h00;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic cmd(input logic [1:0] op, input logic a, input int lim, input bit must);
        cmd_go <= 1'h1;
        cmd_op <= op;
        cmd_arg <= a;
        @(posedge clk);
        cmd_go <= 1'h0;
        done = 1'h0;
        ended = 1'h0;
        rxq.delete();
        for (int i = 0; i < lim && !done; i++)
        begin
            @(posedge clk);
            if (fill_valid === 1'h1) got_fill = fill_out;
            if (rx_valid === 1'h1) rxq.push_back(rx_byte);
            if (rx_end === 1'h1) ended = 1'h1;
            if (busy === 1'h0) done = 1'h1;
        end
        // trailing gap also catches a late end-of-frame pulse
        repeat (20)
        begin
            @(posedge clk);
            if (rx_end === 1'h1) ended = 1'h1;
        end
        if (!done && must)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask : cmd

    initial
    begin
        reset = 1'h1;
        node_select_n = 1'h1;
        cmd_go = 1'h0;
        cmd_op = 2'h0;
        cmd_arg = 1'h0;
        up_en = 1'h0;
        idx = 4;
        fill_in = 14'h0000;
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        node_select_n <= 1'h0;
        up_en <= 1'h1;
        repeat (8) @(posedge clk);
        // ------------------------------------------------------------
        // selected: status corners, bank both ways, one frame
        // ------------------------------------------------------------
        check(16'(selected), 16'h0001);
        for (k = 0; k < 3; k++)
        begin
            fill_in <= (k == 0) ? 14'h3FFF : (k == 1) ? 14'h0000 : 14'($random(seed));
            @(posedge clk);
            cmd(dco_pkg::OP_STATUS, 1'h0, 2000, 1);
            check(16'(got_fill), 16'(fill_in));
        end
        for (k = 1; k >= 0; k--)
        begin
            cmd(dco_pkg::OP_BANK, k[0], 2000, 1);
            check(16'(bank_sel), 16'(k[0]));
        end
        // opcode zero is ignored and must leave the bank alone
        cmd(2'h0, 1'h1, 2000, 1);
        check(16'(bank_sel), 16'h0000);
        foreach (frm[j]) frm[j] = 8'($random(seed));
        idx <= 0;
        @(posedge clk);
        cmd(dco_pkg::OP_SEND, 1'h0, 3000, 1);
        check(16'(rxq.size()), 16'h0004);
        for (k = 0; k < 4; k++) check(16'(rxq[k]), 16'(frm[k]));
        check(16'(ended), 16'h0001);
        // ------------------------------------------------------------
        // deselected: forwarding depth, then silence
        // ------------------------------------------------------------
        node_select_n <= 1'h1;
        repeat (10) @(posedge clk);
        check(16'(selected), 16'h0000);
        for (k = 0; k < 40; k++)
        begin
            @(posedge clk);
            if (k >= 3) check(16'({ch.frame_valid_out_n, ch.chain_byte_out}), 16'(hist[k-3]));
            hist.push_back({ch.frame_valid_in_n, ch.chain_byte_in});
        end
        up_en <= 1'h0;
        repeat (10) @(posedge clk);
        cmd(dco_pkg::OP_STATUS, 1'h0, 600, 0);
        check(16'(done), 16'h0000);
        tally_and_finish();
    end
endmodule : tb_top
